// >>> lcdrl_pkg.sv
// lcdrl_pkg: constants, types and helpers shared by the display-data path.
// assumes one system clock; every count below is in cycles of that clock
// or in ticks of the derived display clock.
package lcdrl_pkg;

  // display memory geometry
  localparam int RAM_WORDS = 160;
  localparam int RAM_ROWS = 4;
  localparam int PTR_W = 8;
  localparam logic [PTR_W-1:0] RAM_LAST = 8'h9F;
  localparam logic [PTR_W-1:0] PTR_RST = 8'h00;
  localparam logic [1:0] SUBADDR_RST = 2'h0;
  localparam logic [2:0] BYTE_LAST = 3'h7;

  // clock generation
  localparam int OSC_DIV = 64;
  localparam int OSC_DIV_W = 6;

  // frame rate: 60 Hz to 90 Hz in 5 Hz steps, nominal display clock in Hz
  localparam int FCLK_NOM_HZ = 1800;
  localparam int FRAME_MIN_HZ = 60;
  localparam int FRAME_STEP_HZ = 5;
  localparam logic [2:0] FRAME_SEL_MAX = 3'h6;
  localparam logic [2:0] FRAME_SEL_RST = 3'h0;
  localparam int TICK_W = 8;

  // register port
  localparam int REG_ADDR_W = 4;
  localparam int REG_DATA_W = 16;
  localparam logic [REG_ADDR_W-1:0] REG_CTRL = 4'h0;
  localparam logic [REG_ADDR_W-1:0] REG_POINTER = 4'h1;
  localparam logic [REG_ADDR_W-1:0] REG_SUBADDR = 4'h2;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS = 4'h3;

  // control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_BIAS_BIT = 2;
  localparam int CTRL_EN_BIT = 3;
  localparam int CTRL_BLINK_LSB = 4;
  localparam int CTRL_FRATE_LSB = 6;

  // status register fields
  localparam int STAT_PTR_LSB = 0;
  localparam int STAT_SUB_LSB = 8;
  localparam int STAT_PHASE_LSB = 10;
  localparam int STAT_BIT_LSB = 12;

  // drive modes; the reset value is 1:4 multiplex
  typedef enum logic [1:0] {
    LCDRL_MODE_1_4 = 2'b00,
    LCDRL_MODE_STATIC = 2'b01,
    LCDRL_MODE_1_2 = 2'b10,
    LCDRL_MODE_1_3 = 2'b11
  } lcdrl_mode_e;

  localparam logic BIAS_THIRD = 1'b0;
  localparam logic [1:0] BLINK_OFF = 2'h0;

  // highest RAM row used by a drive mode
  function automatic logic [1:0] lcdrl_last_row(input lcdrl_mode_e mode);
    unique case (mode)
      LCDRL_MODE_STATIC: lcdrl_last_row = 2'h0;
      LCDRL_MODE_1_2: lcdrl_last_row = 2'h1;
      LCDRL_MODE_1_3: lcdrl_last_row = 2'h2;
      LCDRL_MODE_1_4: lcdrl_last_row = 2'h3;
    endcase
  endfunction : lcdrl_last_row

  // display clock ticks per multiplex phase for a frame rate selection
  function automatic logic [TICK_W-1:0] lcdrl_phase_ticks(input logic [2:0] sel);
    int hz;
    int t;
    hz = FRAME_MIN_HZ + FRAME_STEP_HZ * int'(sel);
    t = FCLK_NOM_HZ / (hz * RAM_ROWS);
    if (t < 1) begin
      t = 1;
    end
    lcdrl_phase_ticks = TICK_W'(t);
  endfunction : lcdrl_phase_ticks

endpackage : lcdrl_pkg

// >>> lcdrl_clkgen.sv
// lcdrl_clkgen: display clock source, internal divider or external pin.
// assumes clk_pin_i is already synchronous to sys_clk_i.
module lcdrl_clkgen
  import lcdrl_pkg::*;
(
  // system
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // source select and enable
  input wire logic osc_sel_i,
  input wire logic enable_i,
  // clock pin
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_o,
  // one-cycle pulse per display clock period
  output logic tick_o
);

  typedef struct packed {
    logic [OSC_DIV_W-1:0] div_cnt;
    logic clk_div;
    logic ext_prev;
    logic tick;
  } lcdrl_clkgen_s;

  localparam logic [OSC_DIV_W-1:0] DIV_LAST = OSC_DIV_W'(OSC_DIV - 1);
  localparam logic [OSC_DIV_W-1:0] DIV_HALF = OSC_DIV_W'(OSC_DIV / 2 - 1);

  lcdrl_clkgen_s s;
  lcdrl_clkgen_s next_s;

  // divide by 64 internally, or take rising edges of the external pin
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    next_s.ext_prev = clk_pin_i;
    if (osc_sel_i) begin
      next_s.div_cnt = '0;
      next_s.clk_div = 1'b0;
      next_s.tick = clk_pin_i & ~s.ext_prev;
    end else begin
      next_s.div_cnt = (s.div_cnt == DIV_LAST) ? '0 : s.div_cnt + 1'b1;
      next_s.tick = (s.div_cnt == DIV_LAST);
      if (s.div_cnt == DIV_HALF || s.div_cnt == DIV_LAST) begin
        next_s.clk_div = ~s.clk_div;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // clock leaves the pin only in internal mode with the display on
  assign clk_pin_o = s.clk_div;
  assign clk_pin_oe_o = ~osc_sel_i & enable_i;
  assign tick_o = s.tick;

endmodule : lcdrl_clkgen

// >>> lcdrl_scan.sv
// lcdrl_scan: display register, segment and backplane outputs.
// assumes load_i pulses once per multiplex phase with row_data_i valid.
module lcdrl_scan
  import lcdrl_pkg::*;
(
  // system
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // scan control
  input wire logic load_i,
  input wire logic [1:0] phase_i,
  input wire lcdrl_mode_e mode_i,
  input wire logic enable_i,
  input wire logic [RAM_WORDS-1:0] row_data_i,
  // outputs
  output logic [RAM_WORDS-1:0] segment_outputs_o,
  output logic [3:0] backplane_o
);

  typedef struct packed {
    logic [RAM_WORDS-1:0] disp_reg;
    logic [3:0] bp;
  } lcdrl_scan_s;

  lcdrl_scan_s s;
  lcdrl_scan_s next_s;
  logic [3:0] phase_hot;

  // latch one RAM row per phase; backplanes follow the drive mode
  always_comb begin
    next_s = s;
    phase_hot = 4'h1 << phase_i;
    if (load_i) begin
      next_s.disp_reg = enable_i ? row_data_i : '0;
      unique case (mode_i)
        LCDRL_MODE_1_4: next_s.bp = phase_hot;
        LCDRL_MODE_1_3: next_s.bp = {phase_hot[1], phase_hot[2:0]};
        LCDRL_MODE_1_2: next_s.bp = {phase_hot[1:0], phase_hot[1:0]};
        LCDRL_MODE_STATIC: next_s.bp = 4'hF;
      endcase
      if (!enable_i) begin
        next_s.bp = 4'h0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign segment_outputs_o = s.disp_reg;
  assign backplane_o = s.bp;

endmodule : lcdrl_scan

// >>> lcdrl_top.sv
// lcdrl_top: display RAM loader and multiplex scan of an LCD segment driver.
// assumes the serial bus engine in front of it delivers data bits one per
// pulse, most significant first, and that all inputs are synchronous.
//
// How it works
// - internal oscillator divided by sixty-four
// - select low: internal clock, driven on pin
// - clock pin driven only while display enabled
// - select high: external pin clock used directly
// - frame rate 60 to 90 Hz, 5 Hz steps; phase 7 ticks at 60, 6 at 65 to 75, 5 at 80 to 90 Hz, one phase per used row
// - shared sync keeps cascaded phases aligned
// - display register holds one column row
// - 160 segments from phase and register bit
// - backplane duplicates depend on drive mode
// - both backplane pin groups driven identically
// - RAM is 160 words of 4 bits
// - address to segment, row to backplane
// - data bits stored on arrival, not ack
// - static: eight addresses, row 0
// - 1:2: rows 0 and 1, four addresses
// - 1:3: three addresses, last row 2 kept
// - 1:4: rows 0 to 3, two addresses
// - host loads pointer, data starts there
// - pointer steps 8, 4, 3, 2 per byte
// - past 159 wrap to 0, subaddress increments
// - write only on subaddress match, pointer still moves
// - reset clears pointer, subaddress, selects 1:4, disables
module lcdrl_top
  import lcdrl_pkg::*;
#(
  parameter int RAM_DEPTH = RAM_WORDS
) (
  // system
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [REG_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [REG_DATA_W-1:0] reg_rdata_o,
  // display data bit stream from the bus engine
  input wire logic data_bit_i,
  input wire logic data_bit_valid_i,
  // straps
  input wire logic osc_sel_i,
  input wire logic hw_subaddress_bit0_i,
  input wire logic hw_subaddress_bit1_i,
  // clock pin, two-way
  input wire logic clk_pin_i,
  output logic clk_pin_o,
  output logic clk_pin_oe_o,
  // cascade sync, open drain
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe_o,
  // lcd drive, bit 0 top pin group, bit 1 bottom pin group
  output logic [1:0] backplane_out_0_o,
  output logic [1:0] backplane_out_1_o,
  output logic [1:0] backplane_out_2_o,
  output logic [1:0] backplane_out_3_o,
  output logic [RAM_WORDS-1:0] segment_outputs_o
);

  // the column logic is sized for exactly this memory
  if (RAM_DEPTH != RAM_WORDS) begin : g_bad_depth
    $error("lcdrl_top: RAM_DEPTH must equal RAM_WORDS");
  end

  typedef struct packed {
    logic [RAM_WORDS-1:0][RAM_ROWS-1:0] ram;
    logic [PTR_W-1:0] ptr;
    logic [1:0] subaddr;
    logic [1:0] row_in;
    logic [2:0] bit_cnt;
    lcdrl_mode_e mode;
    logic bias;
    logic enable;
    logic [1:0] blink;
    logic [2:0] frame_rate;
    logic [1:0] phase;
    logic [TICK_W-1:0] phase_cnt;
    logic load;
    logic sync_drive;
    logic [REG_DATA_W-1:0] rdata;
  } lcdrl_top_s;

  lcdrl_top_s s;
  lcdrl_top_s next_s;

  logic tick;
  logic [1:0] hw_subaddr;
  logic [RAM_WORDS-1:0] row_data;
  logic [3:0] backplane;
  logic [1:0] last_row;
  logic [1:0] scan_last;
  logic [TICK_W-1:0] phase_end;
  logic byte_end;
  logic advance;
  logic sync_seen;

  assign hw_subaddr = {hw_subaddress_bit1_i, hw_subaddress_bit0_i};

  // display clock source and clock pin
  lcdrl_clkgen u_clkgen (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .osc_sel_i(osc_sel_i),
    .enable_i(s.enable),
    .clk_pin_i(clk_pin_i),
    .clk_pin_o(clk_pin_o),
    .clk_pin_oe_o(clk_pin_oe_o),
    .tick_o(tick)
  );

  // the row being shown, one bit per RAM address
  for (genvar c = 0; c < RAM_WORDS; c++) begin : g_col
    assign row_data[c] = s.ram[c][s.phase];
  end

  // display register and drive outputs
  lcdrl_scan u_scan (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .load_i(s.load),
    .phase_i(s.phase),
    .mode_i(s.mode),
    .enable_i(s.enable),
    .row_data_i(row_data),
    .segment_outputs_o(segment_outputs_o),
    .backplane_o(backplane)
  );

  // loader, scan timing and register port in one next-state process
  always_comb begin
    next_s = s;
    next_s.load = 1'b0;
    next_s.sync_drive = 1'b0;
    next_s.rdata = '0;
    last_row = lcdrl_last_row(s.mode);
    scan_last = lcdrl_last_row(s.mode);
    phase_end = lcdrl_phase_ticks(s.frame_rate) - 1'b1;
    byte_end = (s.bit_cnt == BYTE_LAST);
    advance = 1'b0;
    // a sync low that we did not drive ourselves comes from a neighbour
    sync_seen = ~sync_i & ~s.sync_drive;

    // each data bit with a matching subaddress and a pointer up to 159 lands in RAM the cycle it arrives
    if (data_bit_valid_i) begin
      if (s.subaddr == hw_subaddr && s.ptr <= RAM_LAST) begin
        next_s.ram[s.ptr[7:0]][s.row_in] = data_bit_i;
      end
      next_s.bit_cnt = s.bit_cnt + 1'b1;
      // rows of one address fill before the next address
      if (s.row_in == last_row || byte_end) begin
        next_s.row_in = 2'h0;
        advance = 1'b1;
      end else begin
        next_s.row_in = s.row_in + 1'b1;
      end
    end

    // one column step; the byte total is 8, 4, 3 or 2 by mode
    if (advance) begin
      if (s.ptr >= RAM_LAST) begin
        next_s.ptr = PTR_RST;
        next_s.subaddr = s.subaddr + 1'b1;
      end else begin
        next_s.ptr = s.ptr + 1'b1;
      end
    end

    // multiplex phase timing on display clock ticks
    if (tick) begin
      if (s.phase_cnt >= phase_end) begin
        next_s.phase_cnt = '0;
        next_s.load = 1'b1;
        if (s.phase >= scan_last) begin
          next_s.phase = 2'h0;
          next_s.sync_drive = 1'b1;
        end else begin
          next_s.phase = s.phase + 1'b1;
        end
      end else begin
        next_s.phase_cnt = s.phase_cnt + 1'b1;
      end
    end

    // sync puts the sequence straight back to row 0 and reloads the display register
    if (sync_seen) begin
      next_s.phase = 2'h0;
      next_s.phase_cnt = '0;
      next_s.load = 1'b1;
    end

    // register writes; a pointer load restarts the byte as well
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        REG_CTRL: begin
          next_s.mode = lcdrl_mode_e'(reg_wdata_i[CTRL_MODE_LSB +: 2]);
          next_s.bias = reg_wdata_i[CTRL_BIAS_BIT];
          next_s.enable = reg_wdata_i[CTRL_EN_BIT];
          next_s.blink = reg_wdata_i[CTRL_BLINK_LSB +: 2];
          // out of range selections clamp to the fastest rate
          if (reg_wdata_i[CTRL_FRATE_LSB +: 3] > FRAME_SEL_MAX) begin
            next_s.frame_rate = FRAME_SEL_MAX;
          end else begin
            next_s.frame_rate = reg_wdata_i[CTRL_FRATE_LSB +: 3];
          end
          next_s.row_in = 2'h0;
          next_s.bit_cnt = '0;
        end
        REG_POINTER: begin
          next_s.ptr = reg_wdata_i[PTR_W-1:0];
          next_s.row_in = 2'h0;
          next_s.bit_cnt = '0;
        end
        REG_SUBADDR: begin
          next_s.subaddr = reg_wdata_i[1:0];
        end
        default: begin
        end
      endcase
    end

    // read data appear in the following cycle only
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_CTRL: begin
          next_s.rdata[CTRL_MODE_LSB +: 2] = s.mode;
          next_s.rdata[CTRL_BIAS_BIT] = s.bias;
          next_s.rdata[CTRL_EN_BIT] = s.enable;
          next_s.rdata[CTRL_BLINK_LSB +: 2] = s.blink;
          next_s.rdata[CTRL_FRATE_LSB +: 3] = s.frame_rate;
        end
        REG_POINTER: next_s.rdata[PTR_W-1:0] = s.ptr;
        REG_SUBADDR: next_s.rdata[1:0] = s.subaddr;
        REG_STATUS: begin
          next_s.rdata[STAT_PTR_LSB +: PTR_W] = s.ptr;
          next_s.rdata[STAT_SUB_LSB +: 2] = s.subaddr;
          next_s.rdata[STAT_PHASE_LSB +: 2] = s.phase;
          next_s.rdata[STAT_BIT_LSB +: 3] = s.bit_cnt;
        end
        default: next_s.rdata = '0;
      endcase
    end
  end

  // state register; reset leaves RAM contents alone like a static array
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      s.ptr <= PTR_RST;
      s.subaddr <= SUBADDR_RST;
      s.row_in <= 2'h0;
      s.bit_cnt <= '0;
      s.mode <= LCDRL_MODE_1_4;
      s.bias <= BIAS_THIRD;
      s.enable <= 1'b0;
      s.blink <= BLINK_OFF;
      s.frame_rate <= FRAME_SEL_RST;
      s.phase <= 2'h0;
      s.phase_cnt <= '0;
      s.load <= 1'b0;
      s.sync_drive <= 1'b0;
      s.rdata <= '0;
      s.ram <= s.ram;
    end else begin
      s <= next_s;
    end
  end

  // outputs; both pin groups carry the same backplane
  assign reg_rdata_o = s.rdata;
  assign sync_o = 1'b0;
  assign sync_oe_o = s.sync_drive;
  assign backplane_out_0_o = {2{backplane[0]}};
  assign backplane_out_1_o = {2{backplane[1]}};
  assign backplane_out_2_o = {2{backplane[2]}};
  assign backplane_out_3_o = {2{backplane[3]}};

endmodule : lcdrl_top

// >>> lcdrl_top_asserts.sv
// lcdrl_top_asserts: port-level checks of the display-data path.
// assumes every input is synchronous to sys_clk_i; bound into lcdrl_top below.
module lcdrl_top_asserts
  import lcdrl_pkg::*;
(
  // system
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [REG_ADDR_W-1:0] reg_addr_i,
  input wire logic [REG_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [REG_DATA_W-1:0] reg_rdata_o,
  // clock select and pins
  input wire logic osc_sel_i,
  input wire logic clk_pin_o,
  input wire logic clk_pin_oe_o,
  input wire logic sync_o,
  input wire logic sync_oe_o,
  // lcd drive
  input wire logic [1:0] backplane_out_0_o,
  input wire logic [1:0] backplane_out_1_o,
  input wire logic [1:0] backplane_out_2_o,
  input wire logic [1:0] backplane_out_3_o,
  input wire logic [RAM_WORDS-1:0] segment_outputs_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!resetn_i);

  logic en_q;
  logic [3:0] bp_top;

  // shadow of the display enable bit, updated on the same edge as the control register
  always_ff @(posedge sys_clk_i) begin
    if (!resetn_i) begin
      en_q <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == REG_CTRL) begin
      en_q <= reg_wdata_i[CTRL_EN_BIT];
    end
  end
  assign bp_top = {backplane_out_3_o[0], backplane_out_2_o[0], backplane_out_1_o[0], backplane_out_0_o[0]};

  // the external source stops the divider, so a missing edge is only excused with the pin released
  a_clk_div_period: assert property ($rose(clk_pin_o) |-> ##64 ($rose(clk_pin_o) || !clk_pin_oe_o))
    else $error("clock pin period differs from 64 cycles");
  a_clk_pin_drive: assert property (!osc_sel_i && en_q |-> clk_pin_oe_o)
    else $error("clock pin not driven with internal source enabled");
  a_clk_pin_quiet: assert property (!en_q |-> !clk_pin_oe_o)
    else $error("clock pin driven while display disabled");
  a_ext_clk_input: assert property (osc_sel_i |-> !clk_pin_oe_o)
    else $error("clock pin driven with external source");
  a_bp_groups: assert property (backplane_out_0_o[0] == backplane_out_0_o[1] && backplane_out_1_o[0] == backplane_out_1_o[1] && backplane_out_2_o[0] == backplane_out_2_o[1] && backplane_out_3_o[0] == backplane_out_3_o[1])
    else $error("backplane pin groups differ");
  // every enabled phase has an active backplane, so no backplane means a blank display
  a_blank_segs: assert property (bp_top == 4'h0 |-> segment_outputs_o == '0)
    else $error("segments active without a backplane phase");
  a_reset_blank: assert property (!$past(resetn_i) |-> bp_top == 4'h0 && segment_outputs_o == '0 && reg_rdata_o == '0 && !clk_pin_oe_o)
    else $error("outputs not cleared by reset");
  a_sync_pulse: assert property (sync_oe_o |-> !sync_o ##1 (!sync_oe_o) [*8])
    else $error("sync pulse malformed");

  // main scenarios
  c_sync: cover property (sync_oe_o);
  c_static: cover property (bp_top == 4'hF);
  c_clk_on: cover property ($rose(clk_pin_oe_o));
endmodule : lcdrl_top_asserts

bind lcdrl_top lcdrl_top_asserts i_asserts (
  .sys_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .osc_sel_i,
  .clk_pin_o, .clk_pin_oe_o, .sync_o, .sync_oe_o, .backplane_out_0_o, .backplane_out_1_o,
  .backplane_out_2_o, .backplane_out_3_o, .segment_outputs_o
);

// >>> lcdrl_host.sv
// lcdrl_host: behavioural host streaming display bits towards the device.
// assumes the bus engine has already framed bytes; bits leave most significant first.
module lcdrl_host
  import lcdrl_pkg::*;
(
  // system
  input wire logic sys_clk_i,
  // bit stream
  output logic data_bit_o,
  output logic data_bit_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle line at start
  initial begin
    data_bit_o = 1'b0;
    data_bit_valid_o = 1'b0;
  end

  // n bits back to back; a short count is an aborted byte, the bench reloads the pointer
  task automatic send_bits(input logic [7:0] b, input int n);
    for (int k = 7; k > 7 - n; k--) begin
      @(posedge sys_clk_i);
      data_bit_o <= b[k];
      data_bit_valid_o <= 1'b1;
    end
    @(posedge sys_clk_i);
    data_bit_valid_o <= 1'b0;
    data_bit_o <= ~data_bit_o; // released line never keeps the last bit
  endtask : send_bits
endmodule : lcdrl_host

// >>> lcdrl_top_tb.sv
// lcdrl_top_tb: self-checking bench for the display-data path.
// assumes lcdrl_host streams bits; clock pin and sync wire are resolved here.
module lcdrl_top_tb
  import lcdrl_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int PH = OSC_DIV * (FCLK_NOM_HZ / (FRAME_MIN_HZ * RAM_ROWS)); // cycles per phase at 60 Hz
  typedef struct packed {
    lcdrl_mode_e mode;
    logic [7:0] ptr;
    logic [3:0] pre;
    logic [9:0] exp;
  } lcdrl_row_s;
  // mode, start pointer, aborted bits first, expected {subaddress, pointer}
  localparam lcdrl_row_s ROWS [7] = '{
    '{LCDRL_MODE_1_4, 8'h0A, 4'h0, 10'h10C}, '{LCDRL_MODE_STATIC, 8'h14, 4'h0, 10'h11C},
    '{LCDRL_MODE_1_2, 8'h1E, 4'h0, 10'h122}, '{LCDRL_MODE_1_3, 8'h28, 4'h0, 10'h12B},
    '{LCDRL_MODE_1_3, 8'h9E, 4'h0, 10'h201}, '{LCDRL_MODE_STATIC, 8'h9C, 4'h0, 10'h204},
    '{LCDRL_MODE_1_4, 8'h32, 4'h3, 10'h134}};
  logic sys_clk_i, resetn_i, reg_wr_i, reg_rd_i, osc_sel_i, ext_clk;
  logic data_bit_i, data_bit_valid_i, clk_pin_o, clk_pin_oe_o, sync_o, sync_oe_o;
  logic [REG_ADDR_W-1:0] reg_addr_i;
  logic [REG_DATA_W-1:0] reg_wdata_i, reg_rdata_o, rd, rd2;
  logic [1:0] backplane_out_0_o, backplane_out_1_o, backplane_out_2_o, backplane_out_3_o;
  logic [RAM_WORDS-1:0] segment_outputs_o;
  logic [3:0] ext_cnt, bp_top, bp_bot;
  logic [7:0] pat = 8'hA5;
  logic sync_ext = 1'b1; // a neighbour pulling the shared sync wire low
  int n_errors = 0;
  int tests_run = 0;
  assign bp_top = {backplane_out_3_o[0], backplane_out_2_o[0], backplane_out_1_o[0], backplane_out_0_o[0]};
  assign bp_bot = {backplane_out_3_o[1], backplane_out_2_o[1], backplane_out_1_o[1], backplane_out_0_o[1]};

  // straps give subaddress 1; sync wire has a pull-up and is only pulled low
  lcdrl_top i_dut (
    .sys_clk_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .data_bit_i, .data_bit_valid_i, .osc_sel_i, .hw_subaddress_bit0_i(1'b1), .hw_subaddress_bit1_i(1'b0),
    .clk_pin_i(clk_pin_oe_o ? clk_pin_o : ext_clk), .clk_pin_o, .clk_pin_oe_o,
    .sync_i(sync_oe_o ? sync_o : sync_ext), .sync_o, .sync_oe_o, .backplane_out_0_o, .backplane_out_1_o,
    .backplane_out_2_o, .backplane_out_3_o, .segment_outputs_o
  );
  lcdrl_host i_host (.sys_clk_i, .data_bit_o(data_bit_i), .data_bit_valid_o(data_bit_valid_i));

  always #10 sys_clk_i = ~sys_clk_i;
  // external clock keeps running, one rising edge every 20 cycles
  always @(posedge sys_clk_i) begin
    ext_cnt <= (ext_cnt == 4'h9) ? 4'h0 : ext_cnt + 4'h1;
    if (ext_cnt == 4'h9) begin
      ext_clk <= ~ext_clk;
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic reg_write(input logic [REG_ADDR_W-1:0] a, input logic [REG_DATA_W-1:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : reg_write
  // read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [REG_ADDR_W-1:0] a, output logic [REG_DATA_W-1:0] d);
    @(posedge sys_clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    d = reg_rdata_o;
  endtask : reg_read
  task automatic wait_bp(input logic [3:0] want);
    for (int n = 0; n < 4 * PH && bp_top !== want; n++) begin
      @(posedge sys_clk_i);
      #1;
    end
  endtask : wait_bp
  // two phases, so the outputs surely come from a load after the last write
  task automatic settle();
    repeat (2 * PH) @(posedge sys_clk_i);
    #1;
  endtask : settle
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  initial begin
    repeat (60000) @(posedge sys_clk_i);
    n_errors++;
    stop_test();
  end

  initial begin
    sys_clk_i = 1'b0;
    resetn_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    osc_sel_i = 1'b0;
    ext_clk = 1'b0;
    ext_cnt = 4'h0;
    repeat (20) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    reg_read(REG_STATUS, rd);
    check("status", rd, 16'h0000);
    reg_read(REG_CTRL, rd);
    check("ctrl", rd, 16'h0000);
    check("clk oe", {15'h0, clk_pin_oe_o}, 16'h0000);
    // pointer step per mode, wrap in 1:3 and static; a pointer write after an aborted byte restarts it
    foreach (ROWS[i]) begin
      reg_write(REG_CTRL, 16'(ROWS[i].mode) | 16'h0008);
      reg_write(REG_SUBADDR, 16'h0001);
      reg_write(REG_POINTER, 16'(ROWS[i].ptr));
      if (ROWS[i].pre != 4'h0) begin
        i_host.send_bits(8'hFF, int'(ROWS[i].pre));
        reg_write(REG_POINTER, 16'(ROWS[i].ptr));
      end
      i_host.send_bits(8'h5A, 8);
      reg_read(REG_STATUS, rd);
      check("pointer", {6'h0, rd[9:0]}, {6'h0, ROWS[i].exp});
    end
    // 1:4 scan: bits msb first, four rows of two columns
    reg_write(REG_CTRL, 16'h0008);
    reg_write(REG_SUBADDR, 16'h0001);
    reg_write(REG_POINTER, 16'h0000);
    i_host.send_bits(pat, 8);
    settle();
    for (int r = 0; r < 4; r++) begin
      wait_bp(4'(1 << r));
      check("bp phase", {12'h0, bp_top}, 16'(1 << r));
      check("bp groups", {12'h0, bp_bot}, {12'h0, bp_top});
      check("seg col", {14'h0, segment_outputs_o[1:0]}, {14'h0, pat[3-r], pat[7-r]});
    end
    // static: mismatched subaddress suppresses the write but moves the pointer
    reg_write(REG_CTRL, 16'h0009);
    reg_write(REG_POINTER, 16'h0000);
    i_host.send_bits(8'h00, 8);
    reg_write(REG_SUBADDR, 16'h0000);
    reg_write(REG_POINTER, 16'h0000);
    i_host.send_bits(8'hFF, 8);
    reg_read(REG_STATUS, rd);
    check("ptr on mismatch", {6'h0, rd[9:0]}, 16'h0008);
    reg_write(REG_SUBADDR, 16'h0001);
    reg_write(REG_POINTER, 16'h0008);
    i_host.send_bits(8'hB1, 8);
    settle();
    check("static seg", segment_outputs_o[15:0], 16'h8D00);
    check("static bp", {12'h0, bp_top}, 16'h000F);
    // 1:3: the last row of the third address survives a later byte
    reg_write(REG_CTRL, 16'h000B);
    reg_write(REG_POINTER, 16'h0012);
    i_host.send_bits(8'hFF, 8);
    reg_write(REG_POINTER, 16'h0010);
    i_host.send_bits(8'h00, 8);
    settle();
    wait_bp(4'h4);
    check("1:3 row 2", {13'h0, segment_outputs_o[18:16]}, 16'h0004);
    wait_bp(4'hA);
    check("1:3 bp", {12'h0, bp_top}, 16'h000A);
    // 1:2: bits in pairs across rows 0 and 1
    reg_write(REG_CTRL, 16'h000A);
    reg_write(REG_POINTER, 16'h0020);
    i_host.send_bits(8'hC0, 8);
    settle();
    wait_bp(4'h5);
    check("1:2 row 0", {12'h0, segment_outputs_o[35:32]}, 16'h0001);
    wait_bp(4'hA);
    check("1:2 row 1", {12'h0, segment_outputs_o[35:32]}, 16'h0001);
    check("clk oe", {15'h0, clk_pin_oe_o}, 16'h0001);
    // disabled display blanks the drive and releases the clock pin
    reg_write(REG_CTRL, 16'h0000);
    settle();
    check("disabled seg", segment_outputs_o[15:0], 16'h0000);
    check("disabled bp", {12'h0, bp_top}, 16'h0000);
    check("clk oe", {15'h0, clk_pin_oe_o}, 16'h0000);
    // frame rate selection above the top step clamps to 90 Hz
    reg_write(REG_CTRL, 16'h01C8);
    reg_read(REG_CTRL, rd);
    check("frame clamp", rd, 16'h0188);
    // external source: pin stays an input and its edges step the scan
    @(posedge sys_clk_i);
    osc_sel_i <= 1'b1;
    reg_write(REG_CTRL, 16'h0008);
    reg_read(REG_STATUS, rd);
    repeat (150) @(posedge sys_clk_i);
    reg_read(REG_STATUS, rd2);
    check("ext phase moves", {15'h0, rd[11:10] != rd2[11:10]}, 16'h0001);
    check("ext clk oe", {15'h0, clk_pin_oe_o}, 16'h0000);
    // a neighbour's sync pulse puts the scan straight back to phase 0
    @(posedge sys_clk_i);
    sync_ext <= 1'b0;
    @(posedge sys_clk_i);
    sync_ext <= 1'b1;
    reg_read(REG_STATUS, rd);
    check("sync phase", {14'h0, rd[11:10]}, 16'h0000);
    // second reset in mid-run clears pointer and subaddress
    @(posedge sys_clk_i);
    resetn_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    resetn_i <= 1'b1;
    reg_read(REG_STATUS, rd);
    check("status after reset", rd & 16'h03FF, 16'h0000);
    stop_test();
  end
endmodule : lcdrl_top_tb
